// [verilog/dah_core.sv]
// Execution block for the decrement-to-accumulator and halt instructions, with AHB-Lite access.
// Assumes HCLK is CLK, one slave on the bus, single word transfers, synchronous active-low reset.
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`default_nettype none
`include "dah_cfg.svh"

module dah_core
	import dah_pkg::*;
#(
	parameter int AW    = 7,
	parameter int PRE_W = 8,
	parameter int WDOG_W = 8
)(
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output var  logic [31:0] HRDATA,
	output var  logic        HREADYOUT,
	output var  logic        HRESP,
	output var  logic        IRQ,
	output var  logic        CLK_RUN
);

	// ======================================================================
	// Elaboration checks
	if (AW < 1 || AW > 8) begin : g_bad_aw
		$error("dah_core: AW must be 1 to 8");
	end
	if (PRE_W < 1 || PRE_W > 16 || WDOG_W < 1 || WDOG_W > 16) begin : g_bad_wdog
		$error("dah_core: PRE_W and WDOG_W must be 1 to 16");
	end

	// ======================================================================
	// Declarations
	dah_state_type        state_q;
	logic [7:0]           accumulator_reg_q;
	logic                 zero_q;
	logic                 power_down_flag_q;
	logic                 timeout_flag_q;
	logic [AW-1:0]        instr_addr_q;
	logic [AW-1:0]        mem_addr_q;
	logic [PRE_W-1:0]     pre_q;
	logic [WDOG_W-1:0]    watchdog_counter_q;
	logic [`DAH_IRQ_W-1:0] stat_q;
	logic [`DAH_IRQ_W-1:0] stat_d;
	logic [`DAH_IRQ_W-1:0] mask_q;
	logic [`DAH_IRQ_W-1:0] mask_d;
	logic [`DAH_IRQ_W-1:0] events;
	logic                 wr_pend_q;
	logic [31:0]          wr_addr_q;
	logic                 rd_wait_q;
	logic [31:0]          rd_word;
	logic [7:0]           core_rdata;
	logic [7:0]           bus_rdata;
	logic                 addr_ok;
	logic                 stat_rd;
	logic                 cmd_wr;
	logic                 wake_wr;
	logic                 mem_we;
	logic                 dec_go;
	logic                 halt_go;
	logic                 halted;
	logic                 wdt_ovf;
	dah_op_type           op;

	// Full-address match, so aliases above the map read as zero
	function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] off);
		return a == {24'h00_0000, off};
	endfunction : reg_hit

	// ======================================================================
	// Bus decode
	// Address phase is taken only when the previous transfer has completed
	assign addr_ok = HSEL && HTRANS[1] && HREADY;
	assign stat_rd = addr_ok && !HWRITE && reg_hit(HADDR, `DAH_OFF_ISTAT);

	// Data-phase writes land on the edge that ends the data phase
	assign cmd_wr  = wr_pend_q && reg_hit(wr_addr_q, `DAH_OFF_CMD);
	assign wake_wr = wr_pend_q && reg_hit(wr_addr_q, `DAH_OFF_WAKE) && HWDATA[0];
	// Only software writes the array; the decrement has no write-back path
	assign mem_we  = wr_pend_q && reg_hit(wr_addr_q, `DAH_OFF_MDATA);
	assign op      = dah_op_type'(HWDATA[`DAH_CMD_OP_LSB +: 2]);

	// Instructions start only from idle; commands during halt are ignored
	assign halted  = state_q == ST_HALT;
	assign dec_go  = cmd_wr && state_q == ST_IDLE && op == OP_DEC_ACCUM;
	assign halt_go = cmd_wr && state_q == ST_IDLE && op == OP_HALT;
	assign wdt_ovf = !halted && (&pre_q) && (&watchdog_counter_q);

	// Register read mux, evaluated in the address phase
	always_comb begin
		rd_word = 32'h0000_0000;
		if (reg_hit(HADDR, `DAH_OFF_ACCUM)) begin
			rd_word[7:0] = accumulator_reg_q;
		end else if (reg_hit(HADDR, `DAH_OFF_FLAGS)) begin
			rd_word[`DAH_FLG_ZERO]   = zero_q;
			rd_word[`DAH_FLG_PDOWN]  = power_down_flag_q;
			rd_word[`DAH_FLG_TMO]    = timeout_flag_q;
			rd_word[`DAH_FLG_BUSY]   = state_q == ST_READ || state_q == ST_EXEC;
			rd_word[`DAH_FLG_HALTED] = halted;
		end else if (reg_hit(HADDR, `DAH_OFF_WDOG)) begin
			rd_word[WDOG_W-1:0] = watchdog_counter_q;
			rd_word[`DAH_WDOG_PRE_LSB +: PRE_W] = pre_q;
		end else if (reg_hit(HADDR, `DAH_OFF_MADDR)) begin
			rd_word[AW-1:0] = mem_addr_q;
		end else if (reg_hit(HADDR, `DAH_OFF_ISTAT)) begin
			rd_word[`DAH_IRQ_W-1:0] = stat_q;
		end else if (reg_hit(HADDR, `DAH_OFF_IMASK)) begin
			rd_word[`DAH_IRQ_W-1:0] = mask_q;
		end
	end

	// ======================================================================
	// AHB-Lite slave
	// Only the memory data read waits a cycle; every response is OKAY
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 32'h0000_0000;
			rd_wait_q <= 1'b0;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
			HRDATA    <= `DAH_RST_HRDATA;
		end else begin
			wr_pend_q <= addr_ok && HWRITE;
			rd_wait_q <= 1'b0;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
			if (addr_ok) begin
				wr_addr_q <= HADDR;
			end
			if (addr_ok && !HWRITE) begin
				if (reg_hit(HADDR, `DAH_OFF_MDATA)) begin
					rd_wait_q <= 1'b1;
					HREADYOUT <= 1'b0;
				end else begin
					HRDATA <= rd_word;
				end
			end
			if (rd_wait_q) begin
				HRDATA <= {24'h00_0000, bus_rdata};
			end
		end
	end

	// Memory pointer for software access to the data bytes
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			mem_addr_q <= '0;
		end else if (wr_pend_q && reg_hit(wr_addr_q, `DAH_OFF_MADDR)) begin
			mem_addr_q <= HWDATA[AW-1:0];
		end
	end

	// ======================================================================
	// Data memory
	// Core port reads the instruction operand; bus port serves software
	dah_dmem #(
		.AW (AW),
		.DW (8)
	) u_dmem (
		.clk     (CLK),
		.we      (mem_we),
		.waddr   (mem_addr_q),
		.wdata   (HWDATA[7:0]),
		.raddr_a (instr_addr_q),
		.raddr_b (mem_addr_q),
		.rdata_a (core_rdata),
		.rdata_b (bus_rdata)
	);

	// ======================================================================
	// Sequencer
	// Decrement: read cycle, then execute; halt holds until a wake write
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (dec_go) begin
						state_q <= ST_READ;
					end else if (halt_go) begin
						state_q <= ST_HALT;
					end
				end
				ST_READ: begin
					state_q <= ST_EXEC;
				end
				ST_EXEC: begin
					state_q <= ST_IDLE;
				end
				ST_HALT: begin
					if (wake_wr) begin
						state_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Operand address latched with the command
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			instr_addr_q <= '0;
		end else if (dec_go) begin
			instr_addr_q <= HWDATA[`DAH_CMD_ADDR_LSB +: AW];
		end
	end

	// Accumulator and zero flag change only in the execute cycle
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			accumulator_reg_q <= `DAH_RST_ACCUM;
			zero_q            <= 1'b0;
		end else if (state_q == ST_EXEC) begin
			accumulator_reg_q <= core_rdata - 8'h01;
			zero_q            <= core_rdata == 8'h01;
		end
	end

	// Gated clock enable; register only, so no glitch reaches the clock gate
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			CLK_RUN <= 1'b1;
		end else if (halt_go) begin
			CLK_RUN <= 1'b0;
		end else if (halted && wake_wr) begin
			CLK_RUN <= 1'b1;
		end
	end

	// ======================================================================
	// Watchdog
	// Frozen while halted by its !halted enable; it runs on the ungated CLK
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			pre_q              <= '0;
			watchdog_counter_q <= '0;
		end else if (halt_go) begin
			pre_q              <= '0;
			watchdog_counter_q <= '0;
		end else if (!halted) begin
			pre_q <= pre_q + 1'b1;
			if (&pre_q) begin
				watchdog_counter_q <= watchdog_counter_q + 1'b1;
			end
		end
	end

	// Status flags; halt beats a time-out in the same cycle
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			power_down_flag_q <= 1'b0;
			timeout_flag_q    <= 1'b0;
		end else if (halt_go) begin
			power_down_flag_q <= 1'b1;
			timeout_flag_q    <= 1'b0;
		end else if (wdt_ovf) begin
			timeout_flag_q <= 1'b1;
		end
	end

	// ======================================================================
	// Interrupts
	// Set wins over the clear-on-read so no event is lost
	always_comb begin
		events = '0;
		events[`DAH_IRQ_DONE] = state_q == ST_EXEC;
		events[`DAH_IRQ_HALT] = halt_go;
		events[`DAH_IRQ_TMO]  = wdt_ovf;
		stat_d = (stat_rd ? '0 : stat_q) | events;
		mask_d = mask_q;
		if (wr_pend_q && reg_hit(wr_addr_q, `DAH_OFF_IMASK)) begin
			mask_d = HWDATA[`DAH_IRQ_W-1:0];
		end
	end

	// Interrupt line registered from next-state values to stay aligned
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			stat_q <= '0;
			mask_q <= `DAH_RST_IMASK;
			IRQ    <= 1'b0;
		end else begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			IRQ    <= |(stat_d & mask_d);
		end
	end

	// ======================================================================
	// Assertions
	property p_dec_value;
		@(posedge CLK) disable iff (!RST_B)
		state_q == ST_READ ##1 state_q == ST_EXEC |=>
			accumulator_reg_q == $past(core_rdata) - 8'h01;
	endproperty

	a_dec_accum_value: assert property (p_dec_value)
		else $error("accumulator is not operand minus one");

	a_dec_zero_flag: assert property (
		@(posedge CLK) disable iff (!RST_B)
		state_q == ST_EXEC |=> zero_q == (accumulator_reg_q == 8'h00))
		else $error("zero flag disagrees with accumulator");

	a_dec_no_writeback: assert property (
		@(posedge CLK) disable iff (!RST_B)
		mem_we |-> $past(addr_ok && HWRITE && reg_hit(HADDR, `DAH_OFF_MDATA)))
		else $error("data memory written without a bus write");

	a_halt_stops_exec: assert property (
		@(posedge CLK) disable iff (!RST_B)
		halt_go |=> halted && !CLK_RUN ##1 (halted || CLK_RUN))
		else $error("halt did not stop execution and clock");

	a_halt_keeps_regs: assert property (
		@(posedge CLK) disable iff (!RST_B)
		halted && !wake_wr |=>
			$stable(accumulator_reg_q) && $stable(zero_q) && $stable(instr_addr_q))
		else $error("register changed during power-down");

	a_halt_clears_wdt: assert property (
		@(posedge CLK) disable iff (!RST_B)
		halt_go |=> pre_q == '0 && watchdog_counter_q == '0 ##1 watchdog_counter_q == '0)
		else $error("watchdog not cleared by halt");

	a_halt_sets_pdf: assert property (
		@(posedge CLK) disable iff (!RST_B)
		halt_go |=> power_down_flag_q && $stable(zero_q))
		else $error("power-down flag not set by halt");

	a_halt_clears_to: assert property (
		@(posedge CLK) disable iff (!RST_B)
		halt_go |=> !timeout_flag_q [*2])
		else $error("time-out flag not cleared by halt");

	c_dec_done: cover property (
		@(posedge CLK) disable iff (!RST_B) dec_go ##2 state_q == ST_EXEC ##1 IRQ);
	// Power-down in the bench lasts just under sixty cycles
	c_halt_wake: cover property (
		@(posedge CLK) disable iff (!RST_B) halt_go ##[1:300] wake_wr ##1 CLK_RUN);
	c_dec_zero: cover property (
		@(posedge CLK) disable iff (!RST_B) state_q == ST_EXEC ##1 zero_q);
	c_mem_read_wait: cover property (
		@(posedge CLK) disable iff (!RST_B) rd_wait_q && !HREADYOUT);

endmodule : dah_core

`default_nettype wire

// [verilog/dah_cfg.svh]
// Constants of the decrement-and-halt execution block: offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite slave whose byte addresses are decoded from the full HADDR.
//
// Behaviour
// - Decrement instruction reads the addressed data byte and subtracts one.
// - Result goes to the accumulator; zero flag set when result is zero, else cleared.
// - Decrement never writes the decremented value back to data memory.
// - Halt stops instruction execution and gates the system clock off.
// - Halt keeps accumulator, zero flag and operand address; bus writes still reach data memory, MADDR and IMASK.
// - Halt clears the watchdog count and its prescaler.
// - Halt sets the power-down flag; only it and time-out flag change.
// - Halt clears the watchdog time-out flag.
`ifndef DAH_CFG_SVH
`define DAH_CFG_SVH

// ==========================================================================
// Register byte offsets
`define DAH_OFF_CMD       8'h00
`define DAH_OFF_ACCUM     8'h04
`define DAH_OFF_FLAGS     8'h08
`define DAH_OFF_WDOG      8'h0C
`define DAH_OFF_MADDR     8'h10
`define DAH_OFF_MDATA     8'h14
`define DAH_OFF_ISTAT     8'h18
`define DAH_OFF_IMASK     8'h1C
`define DAH_OFF_WAKE      8'h20

// ==========================================================================
// Field positions
`define DAH_CMD_OP_LSB    0
`define DAH_CMD_ADDR_LSB  8
`define DAH_FLG_ZERO      0
`define DAH_FLG_PDOWN     1
`define DAH_FLG_TMO       2
`define DAH_FLG_BUSY      3
`define DAH_FLG_HALTED    4
`define DAH_WDOG_PRE_LSB  16
`define DAH_IRQ_DONE      0
`define DAH_IRQ_HALT      1
`define DAH_IRQ_TMO       2
`define DAH_IRQ_W         3

// ==========================================================================
// Reset values
`define DAH_RST_ACCUM     8'h00
`define DAH_RST_IMASK     3'h0
`define DAH_RST_HRDATA    32'h0000_0000

`endif

// [verilog/dah_pkg.sv]
// Types shared by the decrement-and-halt execution block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package dah_pkg;

	// ======================================================================
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_EXEC = 2'b10,
		ST_HALT = 2'b11
	} dah_state_type;

	// ======================================================================
	// Instruction codes written to the command register
	typedef enum logic [1:0] {
		OP_NOP  = 2'b00,
		OP_DEC_ACCUM = 2'b01,
		OP_HALT = 2'b10,
		OP_RSVD = 2'b11
	} dah_op_type;

endpackage : dah_pkg

`default_nettype wire

// [verilog/dah_dmem.sv]
// Small data memory with one write port and two registered read ports.
// Assumes one clock; read data appear one edge after the address, old data on a same-edge write.
`default_nettype none

module dah_dmem #(
	parameter int AW = 7,
	parameter int DW = 8
)(
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr_a,
	input  wire logic [AW-1:0] raddr_b,
	output var  logic [DW-1:0] rdata_a,
	output var  logic [DW-1:0] rdata_b
);

	// ======================================================================
	// Storage
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Array is not reset: contents survive power-down and soft reset alike
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Two read ports so the core and the bus never wait on each other
	always_ff @(posedge clk) begin
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end

endmodule : dah_dmem

`default_nettype wire

// [sim/dah_core_bench.sv]
// Self-checking bench for the decrement-and-halt block, driven over AHB-Lite.
// Assumes the core and its package are compiled first and that dah_cfg.svh is on the include path.
`default_nettype none
`include "dah_cfg.svh"

module dah_core_bench
	import dah_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ======================================================================
	// Signals
	logic        CLK    = 1'b0;
	logic        RST_B  = 1'b0;
	logic        HSEL   = 1'b0;
	logic [31:0] HADDR  = 32'h0000_0000;
	logic [1:0]  HTRANS = 2'h0;
	logic        HWRITE = 1'b0;
	logic [2:0]  HSIZE  = 3'h2;
	logic [31:0] HWDATA = 32'h0000_0000;
	wire  logic  HREADY;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic        IRQ;
	logic        CLK_RUN;
	int          mismatches = 0;
	int          tests_run  = 0;
	int          cycles     = 0;
	logic [31:0] rd;

	// Single slave, so its ready is the bus ready
	assign HREADY = HREADYOUT;

	// Short watchdog: a time-out every 16 cycles keeps the run brief
	dah_core #(.AW(7), .PRE_W(2), .WDOG_W(2)) DUT (
		.CLK       (CLK),
		.RST_B     (RST_B),
		.HSEL      (HSEL),
		.HADDR     (HADDR),
		.HTRANS    (HTRANS),
		.HWRITE    (HWRITE),
		.HSIZE     (HSIZE),
		.HWDATA    (HWDATA),
		.HREADY    (HREADY),
		.HRDATA    (HRDATA),
		.HREADYOUT (HREADYOUT),
		.HRESP     (HRESP),
		.IRQ       (IRQ),
		.CLK_RUN   (CLK_RUN)
	);

	// ======================================================================
	// Clock, 50 ns period
	always #25 CLK = ~CLK;

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end

	// ======================================================================
	// Reporting
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// One compare for every word or bit result, case equality so X never matches
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ======================================================================
	// Bus master: address phase held until ready, then data phase until ready
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rdv);
		HSEL   <= 1'b1;
		HTRANS <= 2'h2;
		HADDR  <= {24'h00_0000, a};
		HWRITE <= wr;
		HSIZE  <= 3'h2;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HTRANS <= 2'h0;
		HSEL   <= 1'b0;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADY !== 1'b1);
		rdv = HRDATA;
	endtask : xfer

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		xfer(1'b1, a, d, dummy);
	endtask : wr32

	task automatic rd32(input logic [7:0] a);
		xfer(1'b0, a, 32'h0000_0000, rd);
	endtask : rd32

	// ======================================================================
	// Scenarios
	// Reset state, read-only accumulator and an unmapped address
	task automatic t_reset();
		rd32(`DAH_OFF_FLAGS);
		chk(rd & 32'h1B, 32'h0);
		// Ignored codes: reserved op and a wake while running change nothing
		wr32(`DAH_OFF_CMD, 32'h0000_0003);
		wr32(`DAH_OFF_WAKE, 32'h0000_0001);
		rd32(`DAH_OFF_FLAGS);
		chk(rd & 32'h1B, 32'h0);
		chk({31'h0, CLK_RUN}, 32'h1);
		rd32(`DAH_OFF_ISTAT);
		chk(rd & 32'h3, 32'h0);
		chk({31'h0, IRQ}, 32'h0);
		wr32(`DAH_OFF_ACCUM, 32'h0000_0055);
		rd32(`DAH_OFF_ACCUM);
		chk(rd, 32'h0);
		rd32(`DAH_OFF_IMASK);
		chk(rd, 32'h0);
		rd32(8'h40);
		chk(rd, 32'h0);
		chk({31'h0, HRESP}, 32'h0);
	endtask : t_reset

	// Decrement one byte; accumulator, zero flag, memory and done event
	task automatic t_dec(input logic [7:0] v, input logic [6:0] a);
		int n;
		wr32(`DAH_OFF_IMASK, 32'h0000_0001);
		wr32(`DAH_OFF_MADDR, {25'h0, a});
		wr32(`DAH_OFF_MDATA, {24'h0, v});
		wr32(`DAH_OFF_CMD, {17'h0, a, 8'h01});
		n = 0;
		// Bounded poll: busy lasts a few cycles only
		do begin
			rd32(`DAH_OFF_FLAGS);
			n++;
		end while (rd[3] !== 1'b0 && n < 20);
		chk({31'h0, rd[3]}, 32'h0);
		chk({31'h0, rd[0]}, {31'h0, v == 8'h01});
		rd32(`DAH_OFF_ACCUM);
		chk(rd, {24'h0, v - 8'h01});
		rd32(`DAH_OFF_MDATA);
		chk(rd, {24'h0, v});
		chk({31'h0, IRQ}, 32'h1);
		rd32(`DAH_OFF_ISTAT);
		chk(rd & 32'h1, 32'h1);
		@(negedge CLK);
		@(negedge CLK);
		chk({31'h0, IRQ}, 32'h0);
	endtask : t_dec

	// Halt after a time-out; flags, watchdog, retention, freeze, wake
	task automatic t_halt();
		repeat (40) @(posedge CLK);
		rd32(`DAH_OFF_FLAGS);
		chk(rd & 32'h4, 32'h4);
		wr32(`DAH_OFF_IMASK, 32'h0000_0002);
		wr32(`DAH_OFF_CMD, 32'h0000_0002);
		@(negedge CLK);
		chk({31'h0, CLK_RUN}, 32'h0);
		rd32(`DAH_OFF_FLAGS);
		chk(rd & 32'h17, 32'h12);
		rd32(`DAH_OFF_WDOG);
		chk(rd, 32'h0);
		// Watchdog must stay frozen while the clock is gated
		repeat (40) @(posedge CLK);
		rd32(`DAH_OFF_WDOG);
		chk(rd, 32'h0);
		rd32(`DAH_OFF_FLAGS);
		chk(rd & 32'h4, 32'h0);
		wr32(`DAH_OFF_CMD, {17'h0, 7'h40, 8'h01});
		rd32(`DAH_OFF_ACCUM);
		chk(rd, 32'h0000_00FE);
		rd32(`DAH_OFF_MDATA);
		chk(rd, 32'h0000_00FF);
		chk({31'h0, IRQ}, 32'h1);
		rd32(`DAH_OFF_ISTAT);
		chk(rd & 32'h2, 32'h2);
		wr32(`DAH_OFF_WAKE, 32'h0000_0001);
		@(negedge CLK);
		chk({31'h0, CLK_RUN}, 32'h1);
	endtask : t_halt

	// ======================================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		t_reset();
		// Boundary values: to zero, wrap from zero, sign edge, top
		t_dec(8'h01, 7'h00);
		t_dec(8'h00, 7'h7F);
		t_dec(8'h80, 7'h05);
		t_dec(8'hFF, 7'h40);
		t_halt();
		final_report();
	end

endmodule : dah_core_bench

`default_nettype wire
